// ### common/link_pkg.sv
// constants, codes and types shared by the word link board and its helpers
package link_pkg;

    localparam int WORD_W = 16;
    localparam int FIFO_DEPTH = 16;
    localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;

    // -----------------------------------------------------------------
    // select codes
    // -----------------------------------------------------------------
    localparam logic [5:0] DEV_LINK_HD = 6'h1E;
    localparam logic [5:0] DEV_LINK_RX = 6'h20;
    localparam logic [5:0] DEV_LINK_TX = 6'h21;
    localparam int HD_MASK_BIT = 6;

    // -----------------------------------------------------------------
    // command codes
    // -----------------------------------------------------------------
    typedef enum logic [1:0] {
        XFER_NONE = 2'h0,
        XFER_READ = 2'h1,
        XFER_WRITE = 2'h2,
        XFER_FLAGS = 2'h3
    } xfer_t;

    typedef enum logic [1:0] {
        FN_NONE = 2'h0,
        FN_START = 2'h1,
        FN_CLEAR = 2'h2,
        FN_PULSE = 2'h3
    } func_t;

    // kind of an entry sent over the link
    typedef enum logic [1:0] {
        K_FD_DATA = 2'h0,
        K_FD_CTRL = 2'h1,
        K_HD_DATA = 2'h2,
        K_HD_CTRL = 2'h3
    } kind_t;

    localparam int ENTRY_W = 2 + 2 + WORD_W;

    // -----------------------------------------------------------------
    // interlock arbitration
    // -----------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_ARB = 2'h1
    } arb_state_t;

    localparam int CLK_PERIOD_NS = 50;
    localparam int ARB_SETTLE_NS = 400;
    localparam int ARB_SETTLE_CYC = (ARB_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ARB_CNT_W = 4;
    localparam logic [ARB_CNT_W-1:0] ARB_LOAD = ARB_CNT_W'(ARB_SETTLE_CYC - 1);
    localparam logic [ARB_CNT_W-1:0] ARB_ZERO = 4'h0;
    localparam logic [ARB_CNT_W-1:0] ARB_STEP = 4'h1;

    localparam int SYNC_W = 4;

endpackage

// ### src/pin_sync.sv
// three-stage synchroniser; a change is taken once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] q_q;
    wire [W-1:0] agree = ~(s2_q ^ s3_q);
    wire [W-1:0] q_d = (q_q & ~agree) | (s3_q & agree);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            q_q <= '0;
        end else begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
            q_q <= q_d;
        end
    end

    assign q = q_q;
endmodule
`default_nettype wire

// ### src/word_fifo.sv
// first-in first-out word store with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module word_fifo #(
    parameter int WIDTH = 20,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    wire full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    wire empty = (wr_q == rd_q);
    wire push = in_valid && !full;
    wire pop = out_ready && !empty;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            wr_q <= push ? wr_q + 1'b1 : wr_q;
            rd_q <= pop ? rd_q + 1'b1 : rd_q;
        end
    end

    // storage needs no reset; only pointers say what is valid
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_q[AW-1:0]] <= in_data;
        end
    end

    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[rd_q[AW-1:0]];
endmodule
`default_nettype wire

// ### src/word_link_board.sv
// one board of the two-computer word link: duplex ports and interlock port
`timescale 1ns/10ps
`default_nettype none
module word_link_board #(
    parameter bit PRIMARY = 1'b0,
    parameter int FIFO_DEPTH = link_pkg::FIFO_DEPTH
) (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic IO_STROBE,
    input wire logic [5:0] IO_DEV,
    input wire logic [1:0] IO_XFER,
    input wire logic [1:0] IO_FUNC,
    input wire logic [15:0] IO_WDATA,
    output logic IO_READY,
    output logic [15:0] IO_RDATA,
    output logic IO_RVALID,
    output logic RX_BUSY,
    output logic RX_DONE,
    output logic TX_BUSY,
    output logic TX_DONE,
    output logic IL_BUSY,
    output logic IL_DONE,
    output logic RX_IRQ,
    output logic TX_IRQ,
    output logic IL_IRQ,
    output logic LNK_OUT_REQ,
    output logic [1:0] LNK_OUT_KIND,
    output logic [1:0] LNK_OUT_FUNC,
    output logic [15:0] LNK_OUT_DATA,
    input wire logic LNK_OUT_ACK,
    input wire logic LNK_IN_REQ,
    input wire logic [1:0] LNK_IN_KIND,
    input wire logic [1:0] LNK_IN_FUNC,
    input wire logic [15:0] LNK_IN_DATA,
    output logic LNK_IN_ACK,
    output logic LNK_IL_BUSY,
    output logic LNK_IL_REQ,
    input wire logic LNK_PEER_IL_BUSY,
    input wire logic LNK_PEER_IL_REQ
);
    localparam int EW = link_pkg::ENTRY_W;
    localparam int WW = link_pkg::WORD_W;

    // -----------------------------------------------------------------
    // partner pins
    // -----------------------------------------------------------------
    logic [link_pkg::SYNC_W-1:0] sync_q;
    pin_sync #(.W(link_pkg::SYNC_W)) u_sync (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .d({LNK_OUT_ACK, LNK_IN_REQ, LNK_PEER_IL_BUSY, LNK_PEER_IL_REQ}),
        .q(sync_q)
    );
    wire out_ack_s = sync_q[3];
    wire in_req_s = sync_q[2];
    wire peer_il_busy_s = sync_q[1];
    wire peer_il_req_s = sync_q[0];

    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    logic rx_busy_q;
    logic rx_busy_d;
    logic rx_done_q;
    logic rx_done_d;
    logic peer_tx_q;
    logic peer_tx_d;
    logic tx_busy_q;
    logic tx_busy_d;
    logic tx_done_q;
    logic tx_done_d;
    logic il_busy_q;
    logic il_busy_d;
    logic il_done_q;
    logic il_done_d;
    logic il_req_q;
    logic il_req_d;
    logic [WW-1:0] rx_buf_q;
    logic [WW-1:0] hd_buf_q;
    logic [WW-1:0] rdata_q;
    logic rvalid_q;
    logic out_req_q;
    logic in_ack_q;
    logic [EW-1:0] out_entry_q;
    logic [link_pkg::ARB_CNT_W-1:0] arb_cnt_q;
    logic [link_pkg::ARB_CNT_W-1:0] arb_cnt_d;
    link_pkg::arb_state_t state_q;
    link_pkg::arb_state_t state_d;

    // -----------------------------------------------------------------
    // command decode
    // -----------------------------------------------------------------
    logic fifo_in_ready;
    wire arb_idle = (state_q == link_pkg::ST_IDLE);
    // no command is taken while the link queue is full or an arbitration runs
    assign IO_READY = fifo_in_ready && arb_idle;
    wire cmd = IO_STROBE && IO_READY;
    wire rx_cmd = cmd && (IO_DEV == link_pkg::DEV_LINK_RX);
    wire tx_cmd = cmd && (IO_DEV == link_pkg::DEV_LINK_TX);
    wire hd_cmd = cmd && (IO_DEV == link_pkg::DEV_LINK_HD);
    wire fn_s = (IO_FUNC == link_pkg::FN_START);
    wire fn_c = (IO_FUNC == link_pkg::FN_CLEAR);
    wire fn_p = (IO_FUNC == link_pkg::FN_PULSE);
    wire x_read = (IO_XFER == link_pkg::XFER_READ);
    wire x_write = (IO_XFER == link_pkg::XFER_WRITE);
    wire x_flags = (IO_XFER == link_pkg::XFER_FLAGS);

    wire rx_start = rx_cmd && fn_s;
    wire rx_clear = rx_cmd && fn_c;
    wire tx_start = tx_cmd && fn_s;
    wire tx_clear = tx_cmd && fn_c;
    // clear-flags ignores its function code entirely
    wire hd_flags = hd_cmd && x_flags;
    wire hd_write = hd_cmd && x_write;
    wire hd_clear = hd_cmd && !x_flags && fn_c;
    wire hd_pulse = hd_cmd && !x_flags && fn_p;
    wire hd_start = hd_cmd && !x_flags && fn_s && !il_busy_q;

    // -----------------------------------------------------------------
    // outbound entries
    // -----------------------------------------------------------------
    wire rx_ack_push = rx_clear || (rx_start && rx_busy_q);
    wire tx_data_push = tx_cmd && x_write;
    wire tx_ctrl_push = tx_start && !x_write;
    wire hd_ctrl_push = (hd_clear || hd_pulse) && !x_write;
    wire push = rx_ack_push || tx_data_push || tx_ctrl_push || hd_write || hd_ctrl_push;

    // word travels together with its flag effect in the same entry, so the
    // partner never sees done before the buffer holds the word
    wire [1:0] push_kind = tx_data_push ? link_pkg::K_FD_DATA :
                           (rx_ack_push || tx_ctrl_push) ? link_pkg::K_FD_CTRL :
                           hd_write ? link_pkg::K_HD_DATA : link_pkg::K_HD_CTRL;
    wire [1:0] push_func = rx_ack_push ? link_pkg::FN_CLEAR :
                           tx_ctrl_push ? link_pkg::FN_START : IO_FUNC;
    wire [EW-1:0] push_entry = {push_kind, push_func, IO_WDATA};

    logic fifo_out_valid;
    logic [EW-1:0] fifo_out_data;
    wire out_idle = (out_req_q == out_ack_s);
    wire out_take = fifo_out_valid && out_idle;

    word_fifo #(.WIDTH(EW), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .in_valid(push),
        .in_ready(fifo_in_ready),
        .in_data(push_entry),
        .out_valid(fifo_out_valid),
        .out_ready(out_idle),
        .out_data(fifo_out_data)
    );

    // -----------------------------------------------------------------
    // inbound entries
    // -----------------------------------------------------------------
    // kind, function and word are held steady by the sender from the edge on which
    // its request toggles until our acknowledge returns, so they are read
    // without a synchroniser once the toggle is seen
    wire in_new = (in_req_s != in_ack_q);
    wire in_fd_data = in_new && (LNK_IN_KIND == link_pkg::K_FD_DATA);
    wire in_fd_ctrl = in_new && (LNK_IN_KIND == link_pkg::K_FD_CTRL);
    wire in_hd_data = in_new && (LNK_IN_KIND == link_pkg::K_HD_DATA);
    wire in_hd_any = in_hd_data || (in_new && (LNK_IN_KIND == link_pkg::K_HD_CTRL));
    wire peer_tx_start = (in_fd_data || in_fd_ctrl) && (LNK_IN_FUNC == link_pkg::FN_START);
    wire peer_tx_ack = in_fd_ctrl && (LNK_IN_FUNC == link_pkg::FN_CLEAR);
    wire peer_hd_clear = in_hd_any && (LNK_IN_FUNC == link_pkg::FN_CLEAR);
    wire peer_hd_pulse = in_hd_any && (LNK_IN_FUNC == link_pkg::FN_PULSE);

    // -----------------------------------------------------------------
    // interlock arbitration
    // -----------------------------------------------------------------
    // both boards raise a request and wait long enough to see each
    // other's; on a tie only the primary board keeps it
    wire arb_end = (state_q == link_pkg::ST_ARB) && (arb_cnt_q == link_pkg::ARB_ZERO);
    wire arb_win = arb_end && !peer_il_busy_s && (PRIMARY || !peer_il_req_s);
    wire arb_go = hd_start && !peer_il_busy_s;

    always_comb begin
        state_d = state_q;
        arb_cnt_d = arb_cnt_q;
        il_req_d = il_req_q;
        unique case (state_q)
            link_pkg::ST_IDLE: begin
                if (arb_go) begin
                    state_d = link_pkg::ST_ARB;
                    arb_cnt_d = link_pkg::ARB_LOAD;
                    il_req_d = 1'b1;
                end
            end
            link_pkg::ST_ARB: begin
                arb_cnt_d = arb_cnt_q - link_pkg::ARB_STEP;
                if (arb_end) begin
                    state_d = link_pkg::ST_IDLE;
                    arb_cnt_d = link_pkg::ARB_ZERO;
                    il_req_d = 1'b0;
                end
            end
            default: begin
                state_d = link_pkg::ST_IDLE;
                il_req_d = 1'b0;
            end
        endcase
    end

    // -----------------------------------------------------------------
    // flag updates; partner events are applied after local commands, so
    // an interlock set that arrives with a local clear wins; a duplex done is not set
    // -----------------------------------------------------------------
    wire peer_tx_after = peer_tx_q && !rx_ack_push;

    always_comb begin
        rx_busy_d = rx_busy_q;
        rx_done_d = rx_done_q;
        peer_tx_d = peer_tx_after;
        if (rx_start) begin
            rx_busy_d = 1'b1;
            rx_done_d = peer_tx_after;
        end
        if (rx_clear) begin
            rx_busy_d = 1'b0;
            rx_done_d = 1'b0;
        end
        if (peer_tx_start) begin
            peer_tx_d = 1'b1;
            rx_done_d = rx_done_d || rx_busy_d;
        end
    end

    always_comb begin
        tx_busy_d = tx_busy_q;
        tx_done_d = tx_done_q;
        if (tx_start) begin
            tx_busy_d = 1'b1;
            tx_done_d = 1'b0;
        end
        if (tx_clear) begin
            tx_busy_d = 1'b0;
            tx_done_d = 1'b0;
        end
        if (peer_tx_ack) begin
            tx_done_d = tx_busy_d;
            tx_busy_d = 1'b0;
        end
    end

    always_comb begin
        il_busy_d = il_busy_q;
        il_done_d = il_done_q;
        if (hd_clear || hd_pulse) begin
            il_done_d = 1'b0;
        end
        if (hd_flags) begin
            il_busy_d = 1'b0;
            il_done_d = 1'b0;
        end
        if (peer_hd_clear) begin
            il_busy_d = 1'b0;
        end
        // a win landing with a crossing clear is kept: the set wins
        if (arb_win) begin
            il_busy_d = 1'b1;
        end
        if (peer_hd_pulse) begin
            il_done_d = 1'b1;
        end
    end

    // -----------------------------------------------------------------
    // data path
    // -----------------------------------------------------------------
    wire rd_rx = rx_cmd && x_read;
    wire rd_hd = hd_cmd && x_read;
    wire [WW-1:0] rdata_d = rd_rx ? rx_buf_q :
                            rd_hd ? hd_buf_q : link_pkg::WORD_RESET;
    // a local write lands after a crossing one in the same cycle
    wire [WW-1:0] hd_buf_d = hd_write ? IO_WDATA :
                             in_hd_data ? LNK_IN_DATA : hd_buf_q;
    wire [WW-1:0] rx_buf_d = in_fd_data ? LNK_IN_DATA : rx_buf_q;

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            rx_buf_q <= link_pkg::WORD_RESET;
            hd_buf_q <= link_pkg::WORD_RESET;
            rdata_q <= link_pkg::WORD_RESET;
            rvalid_q <= 1'b0;
        end else begin
            rx_buf_q <= rx_buf_d;
            hd_buf_q <= hd_buf_d;
            rdata_q <= (rd_rx || rd_hd || hd_flags) ? rdata_d : rdata_q;
            rvalid_q <= rd_rx || rd_hd || hd_flags;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            rx_busy_q <= 1'b0;
            rx_done_q <= 1'b0;
            peer_tx_q <= 1'b0;
            tx_busy_q <= 1'b0;
            tx_done_q <= 1'b0;
            il_busy_q <= 1'b0;
            il_done_q <= 1'b0;
        end else begin
            rx_busy_q <= rx_busy_d;
            rx_done_q <= rx_done_d;
            peer_tx_q <= peer_tx_d;
            tx_busy_q <= tx_busy_d;
            tx_done_q <= tx_done_d;
            il_busy_q <= il_busy_d;
            il_done_q <= il_done_d;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            state_q <= link_pkg::ST_IDLE;
            arb_cnt_q <= link_pkg::ARB_ZERO;
            il_req_q <= 1'b0;
        end else begin
            state_q <= state_d;
            arb_cnt_q <= arb_cnt_d;
            il_req_q <= il_req_d;
        end
    end

    // toggle handshakes: one entry in flight each way
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            out_req_q <= 1'b0;
            out_entry_q <= '0;
            in_ack_q <= 1'b0;
        end else begin
            out_req_q <= out_take ? !out_req_q : out_req_q;
            out_entry_q <= out_take ? fifo_out_data : out_entry_q;
            in_ack_q <= in_new ? !in_ack_q : in_ack_q;
        end
    end

    // -----------------------------------------------------------------
    // outputs
    // -----------------------------------------------------------------
    assign IO_RDATA = rdata_q;
    assign IO_RVALID = rvalid_q;
    assign RX_BUSY = rx_busy_q;
    assign RX_DONE = rx_done_q;
    assign TX_BUSY = tx_busy_q;
    assign TX_DONE = tx_done_q;
    assign IL_BUSY = il_busy_q;
    assign IL_DONE = il_done_q;
    assign RX_IRQ = rx_done_q;
    assign TX_IRQ = tx_done_q;
    assign IL_IRQ = il_done_q;
    assign LNK_OUT_REQ = out_req_q;
    assign LNK_OUT_KIND = out_entry_q[EW-1 -: 2];
    assign LNK_OUT_FUNC = out_entry_q[EW-3 -: 2];
    assign LNK_OUT_DATA = out_entry_q[WW-1:0];
    assign LNK_IN_ACK = in_ack_q;
    assign LNK_IL_BUSY = il_busy_q;
    assign LNK_IL_REQ = il_req_q;
endmodule
`default_nettype wire

// ### tb/word_link_checker.sv
// port-level assertions for the word link board
`timescale 1ns/10ps
`default_nettype none
module word_link_checker (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic IO_STROBE,
    input wire logic [5:0] IO_DEV,
    input wire logic [1:0] IO_XFER,
    input wire logic [1:0] IO_FUNC,
    input wire logic IO_READY,
    input wire logic [15:0] IO_RDATA,
    input wire logic IO_RVALID,
    input wire logic RX_BUSY,
    input wire logic RX_DONE,
    input wire logic TX_BUSY,
    input wire logic TX_DONE,
    input wire logic IL_BUSY,
    input wire logic IL_DONE,
    input wire logic RX_IRQ,
    input wire logic TX_IRQ,
    input wire logic IL_IRQ,
    input wire logic LNK_IL_REQ
);
    wire logic acc = IO_STROBE && IO_READY;
    wire logic rx_c = acc && IO_DEV == link_pkg::DEV_LINK_RX;
    wire logic tx_c = acc && IO_DEV == link_pkg::DEV_LINK_TX;
    wire logic il_c = acc && IO_DEV == link_pkg::DEV_LINK_HD;
    wire logic f_st = IO_FUNC == link_pkg::FN_START;
    wire logic f_cl = IO_FUNC == link_pkg::FN_CLEAR;
    wire logic x_no = IO_XFER == link_pkg::XFER_NONE;
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    // the command port stays closed for the whole settle time
    sequence arb_hold;
        (LNK_IL_REQ && !IO_READY) [*8] ##1 (!LNK_IL_REQ && IO_READY);
    endsequence
    a_rx_init_busy: assert property (rx_c && f_st |=> RX_BUSY)
        else $error("receive start left busy low");
    a_rx_clear_flags: assert property (rx_c && f_cl |=> !RX_BUSY && !RX_DONE)
        else $error("receive clear left a flag set");
    a_tx_start_flags: assert property (tx_c && f_st |=> TX_BUSY && !TX_DONE)
        else $error("transmit start flags wrong");
    a_tx_clear_flags: assert property (tx_c && f_cl |=> !TX_BUSY && !TX_DONE)
        else $error("transmit clear left a flag set");
    a_duplex_pulse_idle: assert property ((rx_c || tx_c) && x_no
        && IO_FUNC == link_pkg::FN_PULSE |=> $stable({RX_BUSY, RX_DONE, TX_BUSY, TX_DONE}))
        else $error("duplex pulse changed a flag");
    a_il_flags_clear: assert property (il_c && IO_XFER == link_pkg::XFER_FLAGS
        |=> !IL_BUSY && !IL_DONE && IO_RVALID && IO_RDATA == 16'h0000)
        else $error("interlock flag clear wrong");
    a_irq_done_level: assert property ($stable({RX_DONE, TX_DONE, IL_DONE})
        |-> {RX_IRQ, TX_IRQ, IL_IRQ} == {RX_DONE, TX_DONE, IL_DONE})
        else $error("interrupt request differs from done");
    a_arb_window: assert property ($rose(LNK_IL_REQ) |-> arb_hold)
        else $error("arbitration window wrong");
    a_il_busy_won: assert property ($rose(IL_BUSY) |-> $fell(LNK_IL_REQ))
        else $error("interlock busy set outside arbitration");
endmodule
bind word_link_board word_link_checker chk_u (.*);
`default_nettype wire

// ### tb/link_partner.sv
// behavioural far-side board: acks outgoing entries, sends entries on request
`timescale 1ns/10ps
`default_nettype none
module link_partner (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic stall,
    input wire logic busy_in,
    input wire logic req_in,
    input wire logic out_req,
    input wire logic [19:0] out_ent,
    output logic out_ack = 1'b0,
    output logic got = 1'b0,
    output logic [19:0] got_ent,
    output logic in_req = 1'b0,
    output logic [19:0] in_ent = 20'h00000,
    input wire logic in_ack,
    output logic peer_busy,
    output logic peer_req
);
    assign peer_busy = busy_in;
    // raised by the bench to stage a tie with the board's own request
    assign peer_req = req_in;
    assign got_ent = out_ent;
    // stall withholds the ack so the board's queue backs up
    always @(posedge clk) begin
        got <= rst_n && !stall && out_req != out_ack;
        if (!rst_n) begin
            out_ack <= 1'b0;
        end else if (!stall) begin
            out_ack <= out_req;
        end
    end
    task automatic send(input logic [19:0] e);
        int n;
        @(negedge clk);
        in_ent = e;
        @(negedge clk);
        in_req = !in_req;
        n = 0;
        while (in_ack !== in_req && n < 50) begin
            @(negedge clk);
            n++;
        end
    endtask
endmodule
`default_nettype wire

// ### tb/tb_word_link_board.sv
// self-checking bench for the word link board
`timescale 1ns/10ps
`default_nettype none
module tb_word_link_board;
    localparam logic [5:0] RXD = link_pkg::DEV_LINK_RX, TXD = link_pkg::DEV_LINK_TX;
    localparam logic [5:0] ILD = link_pkg::DEV_LINK_HD;
    localparam logic [1:0] XN = link_pkg::XFER_NONE, RD = link_pkg::XFER_READ;
    localparam logic [1:0] WR = link_pkg::XFER_WRITE, NF = link_pkg::FN_NONE;
    localparam logic [1:0] ST = link_pkg::FN_START, CL = link_pkg::FN_CLEAR;
    localparam logic [1:0] PU = link_pkg::FN_PULSE, K0 = link_pkg::K_FD_DATA;
    localparam logic [1:0] K1 = link_pkg::K_FD_CTRL, K2 = link_pkg::K_HD_DATA;
    localparam logic [1:0] K3 = link_pkg::K_HD_CTRL;
    logic SYS_CLK = 1'b0;
    logic RST_N, IO_STROBE, IO_READY, IO_RVALID, LNK_OUT_REQ, LNK_OUT_ACK, LNK_IN_ACK;
    logic RX_BUSY, RX_DONE, TX_BUSY, TX_DONE, IL_BUSY, IL_DONE, RX_IRQ, TX_IRQ, IL_IRQ;
    logic LNK_IL_BUSY, LNK_IL_REQ, stall, pbusy, preq, got;
    wire logic LNK_IN_REQ, LNK_PEER_IL_BUSY, LNK_PEER_IL_REQ;
    logic [5:0] IO_DEV;
    logic [1:0] IO_XFER, IO_FUNC, LNK_OUT_KIND, LNK_OUT_FUNC;
    wire logic [1:0] LNK_IN_KIND, LNK_IN_FUNC;
    logic [15:0] IO_WDATA, IO_RDATA, LNK_OUT_DATA, w;
    wire logic [15:0] LNK_IN_DATA;
    logic [19:0] got_ent;
    logic [39:0] ee;
    logic [39:0] exp_ent[$];
    logic [15:0] exp_rd[$];
    int fails = 0, checks = 0, cycles = 0, n;
    word_link_board #(.PRIMARY(1'b1)) dut_u (.*);
    link_partner p_u (.clk(SYS_CLK), .rst_n(RST_N), .stall(stall), .busy_in(pbusy),
        .out_req(LNK_OUT_REQ), .out_ent({LNK_OUT_KIND, LNK_OUT_FUNC, LNK_OUT_DATA}),
        .out_ack(LNK_OUT_ACK), .got(got), .got_ent(got_ent), .in_req(LNK_IN_REQ),
        .in_ent({LNK_IN_KIND, LNK_IN_FUNC, LNK_IN_DATA}), .in_ack(LNK_IN_ACK),
        .peer_busy(LNK_PEER_IL_BUSY), .peer_req(LNK_PEER_IL_REQ), .req_in(preq));
    always #25 SYS_CLK = !SYS_CLK;
    task automatic chk_bit(input string nm, input logic e, input logic g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s: expected %b, seen %b", nm, e, g);
        end
    endtask
    task automatic chk_vec(input string nm, input logic [19:0] e, input logic [19:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask
    task automatic cmd(input logic [5:0] d, input logic [1:0] x, input logic [1:0] f);
        @(negedge SYS_CLK);
        n = 0;
        while (IO_READY !== 1'b1 && n < 40) begin
            @(negedge SYS_CLK);
            n++;
        end
        {IO_DEV, IO_XFER, IO_FUNC, IO_WDATA} = {d, x, f, w};
        IO_STROBE = 1'b1;
        @(negedge SYS_CLK);
        IO_STROBE = 1'b0;
    endtask
    task automatic rd(input logic [5:0] d, input logic [1:0] f, input logic [15:0] e);
        exp_rd.push_back(e);
        cmd(d, RD, f);
    endtask
    // control entries carry no meaningful word, so only kind and function are compared
    task automatic xp(input logic [1:0] k, input logic [1:0] f, input bit full);
        exp_ent.push_back({full ? 20'hFFFFF : 20'hF0000, k, f, w});
    endtask
    task automatic give_verdict;
        $display("checks %0d, mismatches %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(negedge SYS_CLK) begin
        if (IO_RVALID === 1'b1) begin
            chk_vec("read word", {4'h0, exp_rd.pop_front()}, {4'h0, IO_RDATA});
        end
        if (got === 1'b1) begin
            ee = exp_ent.pop_front();
            chk_vec("link entry", ee[19:0] & ee[39:20], got_ent & ee[39:20]);
        end
    end
    always @(posedge SYS_CLK) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            give_verdict();
        end
    end
    initial begin
        {RST_N, IO_STROBE, stall, pbusy, preq, IO_DEV, IO_XFER, IO_FUNC} = 15'h0000;
        w = $urandom(45632);
        IO_WDATA = w;
        repeat (10) @(negedge SYS_CLK);
        RST_N = 1'b1;
        cmd(RXD, XN, ST);
        chk_bit("rx busy", 1'b1, RX_BUSY);
        chk_bit("rx done", 1'b0, RX_DONE);
        w = $urandom;
        p_u.send({K0, NF, w});
        chk_bit("rx done", 1'b0, RX_DONE);
        p_u.send({K1, ST, w});
        chk_bit("rx done", 1'b1, RX_DONE);
        chk_bit("rx irq", 1'b1, RX_IRQ);
        rd(RXD, NF, w);
        cmd(RXD, XN, PU);
        xp(K1, CL, 1'b0);
        rd(RXD, ST, w);
        xp(K1, CL, 1'b0);
        cmd(RXD, XN, CL);
        chk_bit("rx busy", 1'b0, RX_BUSY);
        p_u.send({K1, ST, w});
        cmd(RXD, XN, ST);
        chk_bit("rx done", 1'b1, RX_DONE);
        w = $urandom;
        xp(K0, ST, 1'b1);
        cmd(TXD, WR, ST);
        chk_bit("tx busy", 1'b1, TX_BUSY);
        p_u.send({K1, CL, w});
        chk_bit("tx done", 1'b1, TX_DONE);
        cmd(TXD, XN, PU);
        chk_bit("tx done", 1'b1, TX_DONE);
        cmd(TXD, XN, CL);
        chk_bit("tx done", 1'b0, TX_DONE);
        stall = 1'b1;
        for (int i = 0; i < 24 && IO_READY === 1'b1; i++) begin
            w = $urandom;
            xp(K0, NF, 1'b1);
            cmd(TXD, WR, NF);
        end
        chk_bit("link ready", 1'b0, IO_READY);
        stall = 1'b0;
        repeat (300) @(negedge SYS_CLK);
        chk_bit("drained", 1'b1, exp_ent.size() == 0);
        pbusy = 1'b1;
        repeat (6) @(negedge SYS_CLK);
        cmd(ILD, XN, ST);
        repeat (10) @(negedge SYS_CLK);
        chk_bit("il busy", 1'b0, IL_BUSY);
        pbusy = 1'b0;
        repeat (6) @(negedge SYS_CLK);
        cmd(ILD, XN, ST);
        repeat (10) @(negedge SYS_CLK);
        chk_bit("il busy", 1'b1, IL_BUSY);
        xp(K2, PU, 1'b1);
        cmd(ILD, WR, PU);
        rd(ILD, NF, w);
        p_u.send({K3, PU, w});
        chk_bit("il done", 1'b1, IL_DONE);
        w = $urandom;
        p_u.send({K2, NF, w});
        xp(K3, PU, 1'b0);
        rd(ILD, PU, w);
        chk_bit("il done", 1'b0, IL_DONE);
        xp(K3, CL, 1'b0);
        cmd(ILD, XN, CL);
        exp_rd.push_back(16'h0000);
        cmd(ILD, link_pkg::XFER_FLAGS, NF);
        chk_bit("il busy", 1'b0, IL_BUSY);
        preq = 1'b1;
        cmd(ILD, XN, ST);
        repeat (10) @(negedge SYS_CLK);
        chk_bit("il busy", 1'b1, IL_BUSY);
        chk_bit("il busy line", 1'b1, LNK_IL_BUSY);
        preq = 1'b0;
        p_u.send({K3, CL, w});
        chk_bit("il busy", 1'b0, IL_BUSY);
        repeat (40) @(negedge SYS_CLK);
        give_verdict();
    end
endmodule
`default_nettype wire
